/* File: design/afe_setup_pkg.sv */
// Register map, field layout and timing constants of the front-end control block
package afe_setup_pkg;
  // Word offsets (byte address = 4 * index)
  localparam logic [3:0] idx_clamp_ref = 4'h0;
  localparam logic [3:0] idx_soft_reset = 4'h1;
  localparam logic [3:0] idx_clamp_colour = 4'h2;
  localparam logic [3:0] idx_sample_detect = 4'h3;
  localparam logic [3:0] idx_test_mux = 4'h4;
  localparam int addr_width = 6;
  // Reset values
  localparam logic [3:0] clamp_ref_code_rst = 4'hf;
  localparam logic [1:0] cds_shift_rst = 2'h1;
  localparam logic [2:0] setup4_low_rst = 3'h5;
  // Field positions
  localparam int clamp_ref_lsb = 0;
  localparam int cds_shift_lsb = 4;
  localparam int clamp_enable_bit = 3;
  localparam int colour_lsb = 4;
  localparam int detect_enable_bit = 0;
  localparam int delay_lsb = 1;
  localparam int polarity_bit = 4;
  localparam int clock_test_bit = 7;
  // CDS shift codes
  localparam logic [1:0] cds_advance_1 = 2'h0;
  localparam logic [1:0] cds_nominal = 2'h1;
  localparam logic [1:0] cds_retard_1 = 2'h2;
  localparam logic [1:0] cds_retard_2 = 2'h3;
  // Nominal reset-sample phase within the master clock cycle
  localparam logic [2:0] cds_nominal_phase = 3'h2;
  localparam logic [7:0] byte_zero = 8'h00;
endpackage

/* File: design/sample_delay_line.sv */
// Delays a one-cycle pulse by a programmed number of master clock periods
`timescale 1ns/1ps
module sample_delay_line
  import afe_setup_pkg::*;
#(
  parameter int depth = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pulse in and delay
  input wire logic pulse_in,
  input wire logic [2:0] delay,
  // Delayed pulse
  output logic pulse_out
);
  typedef struct packed
  {
    logic [depth-1:0] line;
  } state_type;
  state_type state_reg;
  state_type state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.line = {state_reg.line[depth-2:0], pulse_in};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Tap 0 is the input itself, tap n is n periods late
  assign pulse_out = (delay == 3'h0) ? pulse_in : state_reg.line[delay - 3'h1];
endmodule

/* File: design/sample_edge_detect.sv */
// Picks rising or falling edges of the sample strobe as one-cycle pulses
`timescale 1ns/1ps
module sample_edge_detect
  import afe_setup_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Strobe and polarity
  input wire logic strobe,
  input wire logic rising,
  // Edge pulse
  output logic edge_pulse
);
  typedef struct packed
  {
    logic prev;
  } state_type;
  state_type state_reg;
  state_type state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.prev = strobe;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign edge_pulse = rising ? (strobe & ~state_reg.prev) : (~strobe & state_reg.prev);
endmodule

/* File: design/afe_setup_sync_control.sv */
// Control registers, sample-pulse detect and test output mux of the front end
//
// Overview of operation
// [RULE_01] 4-bit clamp reference code, bits 3:0, resets to all ones, drives clamp DAC.
// [RULE_02] Bits 5:4 shift reset sampling: 00 advance, 01 nominal, 10/11 retard one/two.
// [RULE_03] Any write to the soft reset location resets every internal cell; code keeps the bus acknowledge, read data and response.
// [RULE_04] Controller should issue a soft reset after power-up before other writes.
// [RULE_05] Controller always writes 101 to bits 2:0 of the clamp/colour register.
// [RULE_06] Clamping enabled only while clamp enable bit 3 is one; default off.
// [RULE_07] Colour select bits 5:4 pick red, green or blue; 11 reserved.
// [RULE_08] Detect disabled: raw sample strobe goes straight to timing logic.
// [RULE_09] Detect enabled: a detected strobe edge makes the internal sample pulse.
// [RULE_10] Detected pulse delayed by bits 3:1 master clock periods; ignored when disabled.
// [RULE_11] Polarity bit 4: zero picks falling, one picks rising edges.
// [RULE_12] Clock test bit 7 clear: converter data appears on the output pins.
// [RULE_13] Clock test set: bit 3 shows sample pulse, bit 2 video sample clock.
// [RULE_14] Controller writes zero to all reserved upper bits.
// [RULE_15] Clock test set: bit 1 converter clock, bit 0 reset sample clock.
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module afe_setup_sync_control
  import afe_setup_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [addr_width-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Sample strobe and timing inputs
  input wire logic sample_strobe,
  input wire logic video_sample_clk,
  input wire logic converter_clk,
  input wire logic reset_sample_clk,
  input wire logic [3:0] converter_data,
  // Analogue control, sample timing and output pin outputs
  output logic [3:0] clamp_ref_code,
  output logic [1:0] cds_reset_shift,
  output logic clamp_enable,
  output logic [1:0] colour_select,
  output logic internal_sample_pulse,
  output logic [2:0] cds_reset_phase,
  output logic [3:0] output_data_pins
);
  typedef struct packed
  {
    logic [1:0] rst_sync;
    logic [7:0] clamp_ref;
    logic [7:0] clamp_colour;
    logic [7:0] sample_detect;
    logic [7:0] test_mux;
    logic soft_reset;
    logic acked;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic pulse;
    logic [2:0] phase;
    logic [3:0] pins;
  } state_type;

  state_type state_reg;
  state_type state_next;
  // Power-on values of every cell
  localparam state_type state_rst =
  '{
    rst_sync: 2'h0,
    clamp_ref: {2'h0, cds_shift_rst, clamp_ref_code_rst},
    clamp_colour: {5'h00, setup4_low_rst},
    sample_detect: byte_zero,
    test_mux: byte_zero,
    soft_reset: 1'b0,
    acked: 1'b0,
    rdata: 32'h00000000,
    resp: 2'h0,
    pulse: 1'b0,
    phase: cds_nominal_phase,
    pins: 4'h0
  };
  logic sys_rst_n;
  logic cell_rst_n;
  logic edge_pulse;
  logic delayed_pulse;
  logic detect_on;
  logic [3:0] word_index;
  logic mapped;

  assign sys_rst_n = state_reg.rst_sync[1];
  // [RULE_03] Soft reset clears cells
  assign cell_rst_n = sys_rst_n & ~state_reg.soft_reset;
  assign detect_on = state_reg.sample_detect[detect_enable_bit];
  assign word_index = avs_address[addr_width-1:2];
  assign mapped = (avs_address[1:0] == 2'h0) && (word_index <= idx_test_mux);

  // [RULE_11] Edge polarity select
  sample_edge_detect edge_unit
  (
    .clk(ref_clk),
    .rst_n(cell_rst_n),
    .strobe(sample_strobe),
    .rising(state_reg.sample_detect[polarity_bit]),
    .edge_pulse(edge_pulse)
  );

  // [RULE_10] Programmed pulse delay
  sample_delay_line #(.depth(8)) delay_unit
  (
    .clk(ref_clk),
    .rst_n(cell_rst_n),
    .pulse_in(edge_pulse),
    .delay(state_reg.sample_detect[delay_lsb +: 3]),
    .pulse_out(delayed_pulse)
  );

  always_comb
  begin
    state_next = state_reg;
    state_next.rst_sync = {state_reg.rst_sync[0], 1'b1};
    state_next.soft_reset = 1'b0;
    state_next.acked = 1'b0;
    // One wait cycle, then a one-cycle acknowledge
    if ((avs_read || avs_write) && !state_reg.acked)
    begin
      state_next.acked = 1'b1;
      state_next.resp = mapped ? 2'h0 : 2'h2;
      state_next.rdata = '0;
      if (avs_write && mapped && avs_byteenable[0])
      begin
        case (word_index)
          idx_clamp_ref: state_next.clamp_ref = avs_writedata[7:0];
          // [RULE_03] Any data triggers reset
          idx_soft_reset: state_next.soft_reset = 1'b1;
          idx_clamp_colour: state_next.clamp_colour = avs_writedata[7:0];
          idx_sample_detect: state_next.sample_detect = avs_writedata[7:0];
          idx_test_mux: state_next.test_mux = avs_writedata[7:0];
          default: state_next.resp = 2'h2;
        endcase
      end
      else if (avs_read && mapped)
      begin
        case (word_index)
          idx_clamp_ref: state_next.rdata = {24'h000000, state_reg.clamp_ref};
          idx_clamp_colour: state_next.rdata = {24'h000000, state_reg.clamp_colour};
          idx_sample_detect: state_next.rdata = {24'h000000, state_reg.sample_detect};
          idx_test_mux: state_next.rdata = {24'h000000, state_reg.test_mux};
          default: state_next.rdata = '0;
        endcase
      end
    end
    // [RULE_08] Raw strobe when detect off
    // [RULE_09] Detected pulse when on
    state_next.pulse = detect_on ? delayed_pulse : sample_strobe;
    // [RULE_02] Reset sampling phase shift
    case (state_reg.clamp_ref[cds_shift_lsb +: 2])
      cds_advance_1: state_next.phase = cds_nominal_phase - 3'h1;
      cds_nominal: state_next.phase = cds_nominal_phase;
      cds_retard_1: state_next.phase = cds_nominal_phase + 3'h1;
      cds_retard_2: state_next.phase = cds_nominal_phase + 3'h2;
      default: state_next.phase = cds_nominal_phase;
    endcase
    // [RULE_12] Data in normal mode
    // [RULE_13] Timing signals in test mode
    // [RULE_15] Low bits carry clocks
    if (state_reg.test_mux[clock_test_bit])
    begin
      state_next.pins = {state_reg.pulse, video_sample_clk, converter_clk, reset_sample_clk};
    end
    else
    begin
      state_next.pins = converter_data;
    end
    // Held at reset until synchroniser releases
    if (!sys_rst_n)
    begin
      state_next = state_rst;
      state_next.rst_sync = {state_reg.rst_sync[0], 1'b1};
    end
    // [RULE_03] Soft reset restores cells
    else if (state_reg.soft_reset)
    begin
      state_next.clamp_ref = state_rst.clamp_ref;
      state_next.clamp_colour = state_rst.clamp_colour;
      state_next.sample_detect = state_rst.sample_detect;
      state_next.test_mux = state_rst.test_mux;
      state_next.pulse = state_rst.pulse;
      state_next.phase = state_rst.phase;
      state_next.pins = state_rst.pins;
    end
  end

  // [RULE_01] Code resets to all ones
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= state_rst;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign avs_waitrequest = ~state_reg.acked;
  assign avs_readdata = state_reg.rdata;
  assign avs_response = state_reg.resp;
  // [RULE_01] Clamp DAC code
  assign clamp_ref_code = state_reg.clamp_ref[clamp_ref_lsb +: 4];
  assign cds_reset_shift = state_reg.clamp_ref[cds_shift_lsb +: 2];
  // [RULE_06] Clamp enable bit
  assign clamp_enable = state_reg.clamp_colour[clamp_enable_bit];
  // [RULE_07] Colour selection
  assign colour_select = state_reg.clamp_colour[colour_lsb +: 2];
  assign internal_sample_pulse = state_reg.pulse;
  assign cds_reset_phase = state_reg.phase;
  assign output_data_pins = state_reg.pins;

  // [RULE_03] Soft reset restores defaults
  soft_reset_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n) // [RULE_03]
    state_reg.soft_reset |-> ##1 (clamp_ref_code == clamp_ref_code_rst && cds_reset_shift == cds_shift_rst
    && !clamp_enable && output_data_pins == state_rst.pins))
    else $error("soft reset did not restore defaults");
  // [RULE_03] Bus ack survives
  soft_ack_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n) // [RULE_03]
    state_reg.soft_reset |-> !avs_waitrequest)
    else $error("soft reset dropped the bus acknowledge");
  // [RULE_01] Code follows write
  ref_code_write_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_01]
    (avs_write && avs_waitrequest && mapped && avs_byteenable[0] && word_index == idx_clamp_ref)
    |=> clamp_ref_code == $past(avs_writedata[clamp_ref_lsb +: 4]))
    else $error("clamp reference code not written");
  // [RULE_06] Clamp follows write
  clamp_write_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_06]
    (avs_write && avs_waitrequest && mapped && avs_byteenable[0] && word_index == idx_clamp_colour)
    |=> clamp_enable == $past(avs_writedata[clamp_enable_bit]))
    else $error("clamp enable not written");
  // [RULE_07] Colour follows write
  colour_write_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_07]
    (avs_write && avs_waitrequest && mapped && avs_byteenable[0] && word_index == idx_clamp_colour)
    |=> colour_select == $past(avs_writedata[colour_lsb +: 2]))
    else $error("colour select not written");
  // [RULE_08] Raw strobe passed
  raw_strobe_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_08]
    (!detect_on && $past(!detect_on) && $past(cell_rst_n)) |-> internal_sample_pulse == $past(sample_strobe))
    else $error("raw strobe not passed");
  // [RULE_09] Edge makes pulse
  detect_pulse_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_09]
    (detect_on && edge_pulse && state_reg.sample_detect[delay_lsb +: 3] == 3'h0) |-> ##1 internal_sample_pulse)
    else $error("detected edge gave no pulse");
  // [RULE_09] Pulse lasts one cycle
  pulse_single_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_09]
    (detect_on && $past(detect_on) && $stable(state_reg.sample_detect) && internal_sample_pulse)
    |=> (!internal_sample_pulse || !$stable(state_reg.sample_detect)))
    else $error("internal pulse too long");
  // [RULE_10] Three period delay
  pulse_delay_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_10]
    (detect_on && $stable(state_reg.sample_detect) && edge_pulse && state_reg.sample_detect[delay_lsb +: 3] == 3'h3)
    |-> ##4 (internal_sample_pulse || !$stable(state_reg.sample_detect)))
    else $error("pulse delay wrong");
  // [RULE_10] Seven period delay
  pulse_delay7_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_10]
    (detect_on && $stable(state_reg.sample_detect) && edge_pulse && state_reg.sample_detect[delay_lsb +: 3] == 3'h7)
    |-> ##8 (internal_sample_pulse || !$stable(state_reg.sample_detect)))
    else $error("long pulse delay wrong");
  // [RULE_11] Edge polarity
  edge_polarity_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_11]
    (edge_pulse && $past(cell_rst_n)) |-> (sample_strobe == state_reg.sample_detect[polarity_bit]))
    else $error("wrong edge detected");
  // [RULE_12] Data on pins
  data_pins_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_12]
    ($past(!state_reg.test_mux[clock_test_bit]) && $past(cell_rst_n)) |-> output_data_pins == $past(converter_data))
    else $error("data not on output pins");
  // [RULE_13] Upper test bits
  test_pins_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_13]
    ($past(state_reg.test_mux[clock_test_bit]) && $past(cell_rst_n)) |-> output_data_pins[3:2] ==
    {$past(state_reg.pulse), $past(video_sample_clk)})
    else $error("test mux upper bits wrong");
  // [RULE_15] Lower test bits
  test_clocks_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_15]
    ($past(state_reg.test_mux[clock_test_bit]) && $past(cell_rst_n)) |-> output_data_pins[1:0] ==
    {$past(converter_clk), $past(reset_sample_clk)})
    else $error("test mux lower bits wrong");
  // [RULE_02] Retard two periods
  cds_phase_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_02]
    ($stable(cds_reset_shift) && cds_reset_shift == cds_retard_2) |=> cds_reset_phase == cds_nominal_phase + 3'h2)
    else $error("cds phase wrong");
  // [RULE_02] Advance one period
  cds_advance_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_02]
    ($stable(cds_reset_shift) && cds_reset_shift == cds_advance_1) |=> cds_reset_phase == cds_nominal_phase - 3'h1)
    else $error("cds advance phase wrong");
  // [RULE_02] Retard one period
  cds_retard_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_02]
    ($stable(cds_reset_shift) && cds_reset_shift == cds_retard_1) |=> cds_reset_phase == cds_nominal_phase + 3'h1)
    else $error("cds retard phase wrong");
  // [RULE_02] Nominal phase
  cds_nominal_a: assert property (@(posedge ref_clk) disable iff (!cell_rst_n) // [RULE_02]
    ($stable(cds_reset_shift) && cds_reset_shift == cds_nominal) |=> cds_reset_phase == cds_nominal_phase)
    else $error("cds nominal phase wrong");
  cover_detect_c: cover property (@(posedge ref_clk) detect_on && internal_sample_pulse);
  cover_delay_c: cover property (@(posedge ref_clk) detect_on && state_reg.sample_detect[delay_lsb +: 3] == 3'h7
    && internal_sample_pulse);
  cover_test_c: cover property (@(posedge ref_clk) state_reg.test_mux[7]);
  cover_soft_c: cover property (@(posedge ref_clk) state_reg.soft_reset);
  cover_rd_c: cover property (@(posedge ref_clk) avs_read && !avs_waitrequest);
endmodule

/* File: tb/scan_ctrl_model.sv */
// Scanner controller model: sample strobe, timing clocks and converter data
`timescale 1ns/1ps
module scan_ctrl_model
(
  // Clock
  input wire logic ref_clk,
  // Strobe level asked for by the bench
  input wire logic strobe_req,
  // Far-side drive
  output logic sample_strobe,
  output logic video_sample_clk,
  output logic converter_clk,
  output logic reset_sample_clk,
  output logic [3:0] converter_data
);
  logic [3:0] phase_reg = 4'h0;
  logic strobe_reg = 1'b0;
  // Strobe launched just after an edge
  always_ff @(posedge ref_clk)
  begin
    phase_reg <= phase_reg + 4'h1;
    strobe_reg <= strobe_req;
  end
  assign sample_strobe = strobe_reg;
  assign video_sample_clk = phase_reg[0];
  assign converter_clk = phase_reg[1];
  assign reset_sample_clk = phase_reg[0] ^ phase_reg[1];
  assign converter_data = phase_reg ^ 4'h9;
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the front-end control registers and sample path
`timescale 1ns/1ps
module testbench
  import afe_setup_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic strobe_req = 1'b0;
  logic sample_strobe, video_sample_clk, converter_clk, reset_sample_clk;
  logic [3:0] converter_data, clamp_ref_code, output_data_pins;
  logic [1:0] cds_reset_shift, colour_select;
  logic clamp_enable, internal_sample_pulse;
  logic [2:0] cds_reset_phase;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;

  afe_setup_sync_control afe_setup_sync_control_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .sample_strobe(sample_strobe),
    .video_sample_clk(video_sample_clk), .converter_clk(converter_clk),
    .reset_sample_clk(reset_sample_clk), .converter_data(converter_data),
    .clamp_ref_code(clamp_ref_code), .cds_reset_shift(cds_reset_shift), .clamp_enable(clamp_enable),
    .colour_select(colour_select), .internal_sample_pulse(internal_sample_pulse),
    .cds_reset_phase(cds_reset_phase), .output_data_pins(output_data_pins));
  scan_ctrl_model scan_ctrl_model_i (.ref_clk(ref_clk), .strobe_req(strobe_req),
    .sample_strobe(sample_strobe), .video_sample_clk(video_sample_clk), .converter_clk(converter_clk),
    .reset_sample_clk(reset_sample_clk), .converter_data(converter_data));

  always
    #2.5 ref_clk = ~ref_clk;

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic pause();
    repeat (2) @(posedge ref_clk);
  endtask

  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] addr, input logic [7:0] wd,
    output logic [7:0] rd, output logic [1:0] resp);
    int n = 0;
    avs_address <= addr;
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata[7:0];
    resp = avs_response;
    check(avs_waitrequest, 1'b0, "no ack");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [5:0] addr, input logic [7:0] d, input logic [1:0] eresp);
    logic [7:0] r;
    logic [1:0] s;
    bus(1'b1, addr, d, r, s);
    check(s, eresp, "write resp");
  endtask

  task automatic rdc(input logic [5:0] addr, input logic [7:0] exp, input logic [1:0] eresp);
    logic [7:0] r;
    logic [1:0] s;
    bus(1'b0, addr, 8'h00, r, s);
    check(r, exp, "read data");
    check(s, eresp, "read resp");
  endtask

  task automatic t_defaults();
    wr({idx_soft_reset, 2'h0}, 8'h00, 2'h0);
    rdc({idx_clamp_ref, 2'h0}, 8'h1f, 2'h0);
    rdc({idx_clamp_colour, 2'h0}, 8'h05, 2'h0);
    rdc({idx_sample_detect, 2'h0}, 8'h00, 2'h0);
    rdc({idx_test_mux, 2'h0}, 8'h00, 2'h0);
    rdc({idx_soft_reset, 2'h0}, 8'h00, 2'h0);
    check(clamp_ref_code, 4'hf, "ref code");
    check(cds_reset_phase, cds_nominal_phase, "phase");
    check(clamp_enable, 1'b0, "clamp");
  endtask

  task automatic t_fields();
    for (int c = 0; c < 4; c++)
    begin
      wr({idx_clamp_ref, 2'h0}, {2'h0, 2'(c), 4'(c * 5)}, 2'h0);
      pause();
      check(cds_reset_shift, c, "cds");
      check(cds_reset_phase, c + 1, "phase");
      check(clamp_ref_code, c * 5, "ref code");
    end
    for (int k = 0; k < 3; k++)
    begin
      wr({idx_clamp_colour, 2'h0}, {2'h0, 2'(k), k[0], 3'h5}, 2'h0);
      pause();
      check(colour_select, k, "colour");
      check(clamp_enable, k[0], "clamp");
    end
  endtask

  task automatic t_refused();
    wr({4'h7, 2'h0}, 8'h12, 2'h2);
    wr({idx_clamp_ref, 2'h2}, 8'h00, 2'h2);
    rdc({4'h5, 2'h0}, 8'h00, 2'h2);
    rdc({idx_clamp_ref, 2'h0}, 8'h3f, 2'h0);
  endtask

  task automatic t_soft_reset();
    wr({idx_test_mux, 2'h0}, 8'h80, 2'h0);
    wr({idx_soft_reset, 2'h0}, 8'ha5, 2'h0);
    rdc({idx_clamp_ref, 2'h0}, 8'h1f, 2'h0);
    rdc({idx_clamp_colour, 2'h0}, 8'h05, 2'h0);
    rdc({idx_test_mux, 2'h0}, 8'h00, 2'h0);
    check(colour_select, 2'h0, "colour");
  endtask

  task automatic fire(input logic lvl, output int lat, output int cnt);
    lat = -1;
    cnt = 0;
    strobe_req <= lvl;
    for (int i = 1; i <= 16; i++)
    begin
      @(posedge ref_clk);
      if (internal_sample_pulse === 1'b1)
      begin
        cnt++;
        if (lat < 0)
          lat = i;
      end
    end
  endtask

  task automatic t_detect();
    int lat, cnt, base;
    logic [2:0] dly [3] = '{3'h0, 3'h3, 3'h7};
    wr({idx_sample_detect, 2'h0}, 8'h1e, 2'h0);
    fire(1'b1, lat, cnt);
    check(lat, 3, "raw latency");
    check(cnt, 14, "raw level");
    fire(1'b0, lat, cnt);
    for (int p = 0; p < 2; p++)
      for (int j = 0; j < 3; j++)
      begin
        if (p == 1 && j == 0)
        begin
          fire(1'b1, lat, cnt);
          check(cnt, 0, "wrong edge");
        end
        wr({idx_sample_detect, 2'h0}, {3'h0, p[0], dly[j], 1'b1}, 2'h0);
        fire(~p[0], lat, cnt);
        check(cnt, 0, "wrong edge");
        fire(p[0], lat, cnt);
        check(cnt, 1, "pulse count");
        if (j == 0)
          base = lat;
        check(base >= 2 && base <= 5, 1'b1, "detect latency");
        check(lat - base, dly[j], "delay");
      end
  endtask

  task automatic t_mux(input logic sel);
    logic [3:0] prev;
    wr({idx_test_mux, 2'h0}, {sel, 7'h00}, 2'h0);
    pause();
    prev = sel ? {internal_sample_pulse, video_sample_clk, converter_clk, reset_sample_clk} : converter_data;
    for (int i = 0; i < 12; i++)
    begin
      if (i == 4)
        strobe_req <= ~strobe_req;
      @(posedge ref_clk);
      check(output_data_pins, prev, "pins");
      prev = sel ? {internal_sample_pulse, video_sample_clk, converter_clk, reset_sample_clk} : converter_data;
    end
  endtask

  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_defaults();
    t_fields();
    t_refused();
    t_soft_reset();
    t_detect();
    wr({idx_sample_detect, 2'h0}, 8'h00, 2'h0);
    t_mux(1'b1);
    t_mux(1'b0);
    summarize();
  end
endmodule
